// File: shared/timer8_pkg.sv
// package: register map, field layout, modes and constants of the 8-bit timer
package timer8_pkg;

    // register byte offsets on the AXI4-Lite bus
    localparam logic [3:0] OFS_CONTROL = 4'h0;
    localparam logic [3:0] OFS_COUNT   = 4'h4;
    localparam logic [3:0] OFS_COMPARE = 4'h8;
    localparam logic [3:0] OFS_FLAGS   = 4'hC;

    // count extremes
    localparam logic [7:0] COUNT_MAX    = 8'hFF;
    localparam logic [7:0] COUNT_BOTTOM = 8'h00;
    localparam logic [7:0] COUNT_ONE    = 8'h01;

    // control register layout and reset value
    localparam int         CTRL_WIDTH     = 11;
    localparam int         FORCE_BIT      = 7;
    localparam logic [2:0] CLOCK_STOPPED  = 3'h0;
    localparam logic [2:0] CLOCK_FIRST    = 3'h1;
    localparam logic [10:0] CTRL_RESET    = 11'h000;

    // flag register bit positions
    localparam int FLAG_OVERFLOW = 0;
    localparam int FLAG_COMPARE  = 1;

    // prescaler: select n divides the tick source by 2**(n-1)
    localparam int PRESCALE_WIDTH = 6;

    // bus answers
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // counting sequences
    typedef enum logic [1:0] {
        MODE_NORMAL      = 2'h0,
        MODE_PWM_PHASE   = 2'h1,
        MODE_MATCH_CLEAR = 2'h2,
        MODE_PWM_FAST    = 2'h3
    } wave_mode_t;

    // compare output action
    typedef enum logic [1:0] {
        COM_OFF    = 2'h0,
        COM_TOGGLE = 2'h1,
        COM_CLEAR  = 2'h2,
        COM_SET    = 2'h3
    } com_mode_t;

    // control register fields, msb first
    typedef struct packed {
        logic       overflow_irq_enable;
        logic       compare_irq_enable;
        logic       async_clock_select;
        logic       force_compare_strobe;
        com_mode_t  compare_output_bits;
        wave_mode_t waveform_mode_bits;
        logic [2:0] clock_select_bits;
    } ctrl_t;

endpackage : timer8_pkg

// File: design/timer8_counter_compare.sv
// design: 8-bit up/down timer with one compare channel behind an AXI4-Lite slave
//
// Local design decisions: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/1ns

// Functional notes
// - each tick clears, increments or decrements the count, chosen by mode
// - clock select zero means no tick and a stopped counter
// - software reads and writes the count at any time
// - a software count write beats any clear or count in that cycle
// - the two waveform mode bits in control choose the counting sequence
// - overflow flag set per mode and drives an interrupt request
// - eight-bit comparator flags equality of count and compare value
// - a match sets the compare flag on the following tick
// - enabled compare flag requests interrupt; servicing clears the flag
// - writing one to the compare flag bit clears it
// - compare output driven from match, mode, output bits, top and count direction
// - PWM modes double-buffer compare value, loaded at top; others bypass
// - buffered: software reaches buffer; otherwise the active compare value
// - force strobe in non-PWM acts like a match without flag or clear
// - a count write blocks compare matches on the next tick
// - compare output state survives a waveform mode change
// - compare output bits act at once, not buffered
// - top and bottom indications when count is at maximum and zero
// - maximum is FF, bottom 00, top is the maximum in every mode
// - tick from system clock, or from oscillator pin when async selected
// - normal mode counts up, wraps, sets overflow as count becomes zero
// - clear-on-match mode clears the count when it matches compare
module timer8_counter_compare
    import timer8_pkg::*;
(
    // clock and reset
    input  wire logic        MCLK_IN,
    input  wire logic        RST_IN,
    // AXI4-Lite write address and data
    input  wire logic        AWVALID_IN,
    output logic             AWREADY_OUT,
    input  wire logic [3:0]  AWADDR_IN,
    input  wire logic        WVALID_IN,
    output logic             WREADY_OUT,
    input  wire logic [31:0] WDATA_IN,
    input  wire logic [3:0]  WSTRB_IN,
    // AXI4-Lite write response
    output logic             BVALID_OUT,
    input  wire logic        BREADY_IN,
    output logic [1:0]       BRESP_OUT,
    // AXI4-Lite read
    input  wire logic        ARVALID_IN,
    output logic             ARREADY_OUT,
    input  wire logic [3:0]  ARADDR_IN,
    output logic             RVALID_OUT,
    input  wire logic        RREADY_IN,
    output logic [31:0]      RDATA_OUT,
    output logic [1:0]       RRESP_OUT,
    // interrupt requests and their service acknowledges
    output logic             COMPARE_IRQ_OUT,
    input  wire logic        COMPARE_ACK_IN,
    output logic             OVERFLOW_IRQ_OUT,
    input  wire logic        OVERFLOW_ACK_IN,
    // oscillator pin and compare output to the port logic
    input  wire logic        TIMER_OSC_IN,
    output logic             COMPARE_OUTPUT_OUT,
    output logic             PIN_OVERRIDE_OUT
);

    ////////////////////////////////////////////////////////////////////////////////
    // declarations
    ctrl_t                     ctrl_q;
    logic [7:0]                count_q;
    logic [7:0]                compare_q;
    logic [7:0]                compare_buf_q;
    logic                      count_down_q;
    logic                      block_q;
    logic                      compare_flag_q;
    logic                      overflow_flag_q;
    logic                      compare_output_q;
    logic [PRESCALE_WIDTH-1:0] prescale_q;
    logic [2:0]                osc_sync_q;
    logic                      aw_full_q;
    logic                      w_full_q;
    logic [3:0]                waddr_q;
    logic [31:0]               wdata_q;
    logic [3:0]                wstrb_q;
    logic                      bvalid_q;
    logic [1:0]                bresp_q;
    logic                      rvalid_q;
    logic [31:0]               rdata_q;
    logic [1:0]                rresp_q;
    logic                      wr_go;
    logic                      wr_lane0;
    logic                      wr_count;
    logic                      wr_compare;
    logic                      wr_ctrl;
    logic                      wr_flags;
    logic                      src_tick;
    logic                      tick;
    logic                      match;
    logic                      at_top;
    logic                      at_bottom;
    logic                      pwm_mode;
    logic                      hit;
    logic                      force_hit;
    logic                      wrap_max;
    logic [31:0]               ctrl_merged;
    logic [31:0]               strb_mask;
    logic [31:0]               read_word;

    ////////////////////////////////////////////////////////////////////////////////
    // AXI4-Lite write side: address and data taken in either order
    assign AWREADY_OUT = ~aw_full_q;
    assign WREADY_OUT  = ~w_full_q;
    assign BVALID_OUT  = bvalid_q;
    assign BRESP_OUT   = bresp_q;
    assign wr_go       = aw_full_q & w_full_q & ~bvalid_q;
    assign wr_lane0    = wr_go & wstrb_q[0];

    // hold each half until both are present and the response has gone
    always_ff @(posedge MCLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            aw_full_q <= 1'b0;
            w_full_q  <= 1'b0;
            waddr_q   <= 4'h0;
            wdata_q   <= 32'h0000_0000;
            wstrb_q   <= 4'h0;
        end else begin
            if (AWVALID_IN && !aw_full_q) begin
                aw_full_q <= 1'b1;
                waddr_q   <= AWADDR_IN;
            end else if (wr_go) begin
                aw_full_q <= 1'b0;
            end
            if (WVALID_IN && !w_full_q) begin
                w_full_q <= 1'b1;
                wdata_q  <= WDATA_IN;
                wstrb_q  <= WSTRB_IN;
            end else if (wr_go) begin
                w_full_q <= 1'b0;
            end
        end
    end

    // write decode; unmapped addresses answer with an error and change nothing
    always_comb begin
        wr_count   = 1'b0;
        wr_compare = 1'b0;
        wr_ctrl    = 1'b0;
        wr_flags   = 1'b0;
        if (waddr_q == OFS_CONTROL) begin
            wr_ctrl = wr_go;
        end else if (waddr_q == OFS_COUNT) begin
            wr_count = wr_lane0;
        end else if (waddr_q == OFS_COMPARE) begin
            wr_compare = wr_lane0;
        end else if (waddr_q == OFS_FLAGS) begin
            wr_flags = wr_lane0;
        end
    end

    // write response
    always_ff @(posedge MCLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            bvalid_q <= 1'b0;
            bresp_q  <= RESP_OKAY;
        end else if (wr_go) begin
            bvalid_q <= 1'b1;
            bresp_q  <= (waddr_q[1:0] == 2'h0) ? RESP_OKAY : RESP_SLVERR;
        end else if (BREADY_IN) begin
            bvalid_q <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // control register, byte lanes merged; the force strobe is never stored
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            strb_mask[i*8 +: 8] = {8{wstrb_q[i]}};
        end
        ctrl_merged = ({21'h000000, ctrl_q} & ~strb_mask) | (wdata_q & strb_mask);
        ctrl_merged[FORCE_BIT] = 1'b0;
    end

    // mode and output bits take effect on the next clock, no buffering
    always_ff @(posedge MCLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            ctrl_q <= ctrl_t'(CTRL_RESET);
        end else if (wr_ctrl) begin
            ctrl_q <= ctrl_t'(ctrl_merged[CTRL_WIDTH-1:0]);
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // AXI4-Lite read side
    assign ARREADY_OUT = ~rvalid_q;
    assign RVALID_OUT  = rvalid_q;
    assign RDATA_OUT   = rdata_q;
    assign RRESP_OUT   = rresp_q;

    // read mux; the compare offset shows the copy that software writes
    always_comb begin
        read_word = 32'h0000_0000;
        if (ARADDR_IN == OFS_CONTROL) begin
            read_word[CTRL_WIDTH-1:0] = ctrl_q;
        end else if (ARADDR_IN == OFS_COUNT) begin
            read_word[7:0] = count_q;
        end else if (ARADDR_IN == OFS_COMPARE) begin
            read_word[7:0] = pwm_mode ? compare_buf_q : compare_q;
        end else if (ARADDR_IN == OFS_FLAGS) begin
            read_word[FLAG_OVERFLOW] = overflow_flag_q;
            read_word[FLAG_COMPARE]  = compare_flag_q;
        end
    end

    // read data is captured at the address handshake
    always_ff @(posedge MCLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            rvalid_q <= 1'b0;
            rdata_q  <= 32'h0000_0000;
            rresp_q  <= RESP_OKAY;
        end else if (ARVALID_IN && !rvalid_q) begin
            rvalid_q <= 1'b1;
            rdata_q  <= read_word;
            rresp_q  <= (ARADDR_IN[1:0] == 2'h0) ? RESP_OKAY : RESP_SLVERR;
        end else if (RREADY_IN) begin
            rvalid_q <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // tick source: the oscillator pin is two-stage synchronised, then edge-detected
    always_ff @(posedge MCLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            osc_sync_q <= 3'h0;
        end else begin
            osc_sync_q <= {osc_sync_q[1:0], TIMER_OSC_IN};
        end
    end

    // pin edges are seen only when the pin runs at no more than half the system clock
    assign src_tick = ctrl_q.async_clock_select ? (osc_sync_q[1] & ~osc_sync_q[2]) : 1'b1;

    // free-running prescaler on the selected source
    always_ff @(posedge MCLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            prescale_q <= '0;
        end else if (src_tick) begin
            prescale_q <= prescale_q + 1'b1;
        end
    end

    // select zero yields no tick at all
    always_comb begin
        tick = 1'b0;
        if (ctrl_q.clock_select_bits != CLOCK_STOPPED) begin
            tick = src_tick;
            for (int i = 0; i < PRESCALE_WIDTH; i++) begin
                if (i < int'(ctrl_q.clock_select_bits - CLOCK_FIRST) && !prescale_q[i]) begin
                    tick = 1'b0;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // comparator and extreme-value indications
    assign pwm_mode  = ctrl_q.waveform_mode_bits[0];
    assign match     = (count_q == compare_q);
    assign at_top    = (count_q == COUNT_MAX);
    assign at_bottom = (count_q == COUNT_BOTTOM);
    assign hit       = tick & match & ~block_q;
    assign wrap_max  = tick & at_top & (ctrl_q.waveform_mode_bits != MODE_PWM_PHASE);
    assign force_hit = wr_ctrl & wstrb_q[0] & wdata_q[FORCE_BIT] & ~pwm_mode;

    ////////////////////////////////////////////////////////////////////////////////
    // counter unit; a software write overrides whatever the tick would do
    always_ff @(posedge MCLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            count_q      <= COUNT_BOTTOM;
            count_down_q <= 1'b0;
        end else if (wr_count) begin
            count_q <= wdata_q[7:0];
        end else if (tick) begin
            case (ctrl_q.waveform_mode_bits)
                MODE_MATCH_CLEAR: begin
                    count_q <= match ? COUNT_BOTTOM : count_q + COUNT_ONE;
                end
                MODE_PWM_PHASE: begin
                    if (at_top) begin
                        count_down_q <= 1'b1;
                        count_q      <= count_q - COUNT_ONE;
                    end else if (at_bottom) begin
                        count_down_q <= 1'b0;
                        count_q      <= count_q + COUNT_ONE;
                    end else if (count_down_q) begin
                        count_q <= count_q - COUNT_ONE;
                    end else begin
                        count_q <= count_q + COUNT_ONE;
                    end
                end
                default: begin
                    count_q <= count_q + COUNT_ONE; // wraps FF to 00
                end
            endcase
        end
    end

    // a count write arms the block, the next tick consumes it
    always_ff @(posedge MCLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            block_q <= 1'b0;
        end else if (wr_count) begin
            block_q <= 1'b1;
        end else if (tick) begin
            block_q <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // compare value: buffered in PWM, loaded at top; direct otherwise
    always_ff @(posedge MCLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            compare_q     <= COUNT_BOTTOM;
            compare_buf_q <= COUNT_BOTTOM;
        end else begin
            if (wr_compare) begin
                compare_buf_q <= wdata_q[7:0];
            end
            if (wr_compare && !pwm_mode) begin
                compare_q <= wdata_q[7:0];
            end else if (pwm_mode && tick && at_top) begin
                compare_q <= compare_buf_q;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // flags: hardware set wins over software clear and interrupt service
    always_ff @(posedge MCLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            compare_flag_q <= 1'b0;
        end else if (hit) begin
            compare_flag_q <= 1'b1;
        end else if (COMPARE_ACK_IN || (wr_flags && wdata_q[FLAG_COMPARE])) begin
            compare_flag_q <= 1'b0;
        end
    end

    // overflow at max in normal, clear-on-match and fast PWM; at bottom in phase
    always_ff @(posedge MCLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            overflow_flag_q <= 1'b0;
        end else if (!wr_count && (wrap_max || (tick && at_bottom
                     && ctrl_q.waveform_mode_bits == MODE_PWM_PHASE))) begin
            overflow_flag_q <= 1'b1;
        end else if (OVERFLOW_ACK_IN || (wr_flags && wdata_q[FLAG_OVERFLOW])) begin
            overflow_flag_q <= 1'b0;
        end
    end

    assign COMPARE_IRQ_OUT  = compare_flag_q & ctrl_q.compare_irq_enable;
    assign OVERFLOW_IRQ_OUT = overflow_flag_q & ctrl_q.overflow_irq_enable;

    ////////////////////////////////////////////////////////////////////////////////
    // waveform generator; state is kept across mode changes
    always_ff @(posedge MCLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            compare_output_q <= 1'b0;
        end else if (!pwm_mode && (hit || force_hit)) begin
            case (ctrl_q.compare_output_bits)
                COM_TOGGLE: compare_output_q <= ~compare_output_q;
                COM_CLEAR:  compare_output_q <= 1'b0;
                COM_SET:    compare_output_q <= 1'b1;
                default:    compare_output_q <= compare_output_q;
            endcase
        end else if (pwm_mode && ctrl_q.compare_output_bits[1] && tick) begin
            // fast: match sets the off level, top the on level
            if (ctrl_q.waveform_mode_bits == MODE_PWM_FAST) begin
                if (hit) begin
                    compare_output_q <= ctrl_q.compare_output_bits[0];
                end else if (at_top) begin
                    compare_output_q <= ~ctrl_q.compare_output_bits[0];
                end
            end else if (hit) begin
                // phase: up-count match clears, down-count match sets
                compare_output_q <= ctrl_q.compare_output_bits[0] ^ count_down_q;
            end
        end
    end

    assign COMPARE_OUTPUT_OUT = compare_output_q;
    assign PIN_OVERRIDE_OUT   = (ctrl_q.compare_output_bits != COM_OFF);

    ////////////////////////////////////////////////////////////////////////////////
    // checks
    sequence count_write_s;
        wr_count;
    endsequence

    sequence stopped_s;
        ctrl_q.clock_select_bits == CLOCK_STOPPED;
    endsequence

    property write_wins_p;
        @(posedge MCLK_IN) disable iff (RST_IN)
        count_write_s |=> count_q == $past(wdata_q[7:0]);
    endproperty

    stopped_holds_a: assert property (@(posedge MCLK_IN) disable iff (RST_IN)
        stopped_s ##0 !wr_count |=> $stable(count_q))
        else $error("count moved while stopped");

    count_write_a: assert property (write_wins_p)
        else $error("count write did not take priority");

    match_blocked_a: assert property (@(posedge MCLK_IN) disable iff (RST_IN)
        count_write_s ##1 tick |-> !hit)
        else $error("match not blocked after count write");

    flag_set_a: assert property (@(posedge MCLK_IN) disable iff (RST_IN)
        tick && match && !block_q |=> compare_flag_q)
        else $error("compare flag not set on match tick");

    irq_service_a: assert property (@(posedge MCLK_IN) disable iff (RST_IN)
        COMPARE_ACK_IN && !hit |=> !compare_flag_q)
        else $error("compare flag not cleared by interrupt service");

    flag_clear_a: assert property (@(posedge MCLK_IN) disable iff (RST_IN)
        wr_flags && wdata_q[FLAG_COMPARE] && !hit |=> !compare_flag_q)
        else $error("compare flag not cleared by write of one");

    match_clear_a: assert property (@(posedge MCLK_IN) disable iff (RST_IN)
        tick && match && !wr_count && ctrl_q.waveform_mode_bits == MODE_MATCH_CLEAR
        |=> count_q == COUNT_BOTTOM)
        else $error("clear-on-match did not clear");

    normal_wrap_a: assert property (@(posedge MCLK_IN) disable iff (RST_IN)
        tick && at_top && !wr_count && ctrl_q.waveform_mode_bits == MODE_NORMAL
        |=> count_q == COUNT_BOTTOM && overflow_flag_q)
        else $error("normal wrap or overflow flag wrong");

    buffer_load_a: assert property (@(posedge MCLK_IN) disable iff (RST_IN)
        pwm_mode && !(tick && at_top) |=> $stable(compare_q))
        else $error("active compare changed away from top");

    force_no_flag_a: assert property (@(posedge MCLK_IN) disable iff (RST_IN)
        force_hit && !hit && !compare_flag_q && !wr_count && !tick |=> !compare_flag_q
        && $stable(count_q))
        else $error("force strobe touched flag or count");

endmodule : timer8_counter_compare

// File: dv/timer8_isr_model.sv
// partner: interrupt service model that acknowledges a request after a short delay
`timescale 1ns/1ns
module timer8_isr_model (
    // clock and reset
    input  wire logic clk_in,
    input  wire logic rst_in,
    // request, service enable and acknowledge
    input  wire logic irq_in,
    input  wire logic svc_en_in,
    output logic      ack_out
);
    logic [1:0] wait_q;
    ////////////////////////////////////////////////////////////////
    // three cycles of latency, as a cpu finishing its instruction; one-cycle ack
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            wait_q  <= 2'h0;
            ack_out <= 1'b0;
        end else begin
            ack_out <= 1'b0;
            wait_q  <= (irq_in && svc_en_in && !ack_out) ? wait_q + 2'h1 : 2'h0;
            if (wait_q == 2'h2) ack_out <= 1'b1;
        end
    end
endmodule : timer8_isr_model

// File: dv/timer8_counter_compare_tb_top.sv
// testbench: register-level checks of the 8-bit timer over AXI4-Lite
`timescale 1ns/1ns
module timer8_counter_compare_tb_top import timer8_pkg::*; ;
    logic        clk = 1'b0, rst = 1'b1, svc_en = 1'b0, osc = 1'b0;
    logic        awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0;
    logic [3:0]  awaddr = 4'h0, araddr = 4'h0;
    logic [31:0] wdata = 32'h0, rdata, d, c0;
    logic [1:0]  bresp, rresp, r;
    logic        awready, wready, bvalid, arready, rvalid, cirq, oirq, cack, oack, oc, ovr;
    int          n_fail = 0, tests_run = 0, k;
    ////////////////////////////////////////////////////////////////
    // clock, and an oscillator pin that rises every second clock
    initial forever #50 clk = ~clk;
    always @(posedge clk) osc <= ~osc;
    timer8_counter_compare i_timer8_counter_compare (
        .MCLK_IN(clk), .RST_IN(rst), .AWVALID_IN(awvalid), .AWREADY_OUT(awready),
        .AWADDR_IN(awaddr), .WVALID_IN(wvalid), .WREADY_OUT(wready), .WDATA_IN(wdata),
        .WSTRB_IN(4'hF), .BVALID_OUT(bvalid), .BREADY_IN(1'b1), .BRESP_OUT(bresp),
        .ARVALID_IN(arvalid), .ARREADY_OUT(arready), .ARADDR_IN(araddr),
        .RVALID_OUT(rvalid), .RREADY_IN(1'b1), .RDATA_OUT(rdata), .RRESP_OUT(rresp),
        .COMPARE_IRQ_OUT(cirq), .COMPARE_ACK_IN(cack), .OVERFLOW_IRQ_OUT(oirq),
        .OVERFLOW_ACK_IN(oack), .TIMER_OSC_IN(osc), .COMPARE_OUTPUT_OUT(oc),
        .PIN_OVERRIDE_OUT(ovr));
    timer8_isr_model i_timer8_isr_model (.clk_in(clk), .rst_in(rst), .irq_in(cirq),
        .svc_en_in(svc_en), .ack_out(cack));
    timer8_isr_model i_timer8_isr_model_ovf (.clk_in(clk), .rst_in(rst), .irq_in(oirq),
        .svc_en_in(svc_en), .ack_out(oack));
    ////////////////////////////////////////////////////////////////
    // verdict, hang and compare
    task automatic give_verdict;
        $display("comparisons %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : give_verdict
    task automatic hang;
        n_fail++;
        $display("CHECK FAILED at %0t: wait ran out", $time);
        give_verdict();
    endtask : hang
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        tests_run++;
        if (g !== e) begin
            n_fail++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, g, e);
        end
    endtask : chk
    // bready and rready stay high, so each answer is taken at the edge it is seen
    task automatic wr(input logic [3:0] a, input logic [31:0] v);
        int n;
        n = 0;
        awvalid <= 1'b1;
        awaddr  <= a;
        wvalid  <= 1'b1;
        wdata   <= v;
        do begin
            @(posedge clk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            n++;
            if (n > 100) hang();
        end while (!bvalid);
        r = bresp;
    endtask : wr
    task automatic rd(input logic [3:0] a, output logic [31:0] v);
        int n;
        n = 0;
        arvalid <= 1'b1;
        araddr  <= a;
        do begin
            @(posedge clk);
            if (arvalid && arready) arvalid <= 1'b0;
            n++;
            if (n > 100) hang();
        end while (!rvalid);
        v = rdata;
        r = rresp;
    endtask : rd
    task automatic rc(input logic [3:0] a, input logic [31:0] e);
        rd(a, d);
        chk(d, e);
    endtask : rc
    task automatic run(input logic [31:0] ctrl, input int cycles);
        wr(OFS_CONTROL, ctrl);
        repeat (cycles) @(posedge clk);
        wr(OFS_CONTROL, 32'h0);
    endtask : run
    ////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        rc(OFS_CONTROL, 32'h0);
        rd(4'h2, d);
        chk({30'h0, r}, {30'h0, RESP_SLVERR});
        chk(d, 32'h0);
        $display("test reset finished");
        wr(OFS_COUNT, 32'h10);
        repeat (20) @(posedge clk);
        rc(OFS_COUNT, 32'h10);
        run(32'h101, 60);
        rd(OFS_COUNT, d);
        chk(32'(d > 32'h18 && d < 32'h40), 32'h1);
        $display("test stopped and oscillator finished");
        wr(OFS_COMPARE, 32'h20);
        wr(OFS_COUNT, 32'h20);
        run(32'h1, 5);
        wr(OFS_CONTROL, 32'h1);
        wr(OFS_COUNT, 32'h20);
        wr(OFS_CONTROL, 32'h0);
        rc(OFS_FLAGS, 32'h0);
        wr(OFS_COUNT, 32'hF0);
        run(32'h1, 60);
        rc(OFS_FLAGS, 32'h3);
        wr(OFS_FLAGS, 32'h3);
        rc(OFS_FLAGS, 32'h0);
        $display("test normal mode finished");
        wr(OFS_COUNT, 32'h0);
        run(32'h11, 40);
        rd(OFS_COUNT, d);
        chk(32'(d <= 32'h20), 32'h1);
        rc(OFS_FLAGS, 32'h2);
        wr(OFS_CONTROL, 32'h200);
        chk(32'(cirq), 32'h1);
        svc_en <= 1'b1;
        for (k = 0; k < 20 && cirq; k++) @(posedge clk);
        if (cirq) hang();
        rc(OFS_FLAGS, 32'h0);
        svc_en <= 1'b0;
        $display("test clear on match finished");
        rd(OFS_COUNT, c0);
        wr(OFS_CONTROL, 32'h20);
        chk(32'(ovr), 32'h1);
        wr(OFS_CONTROL, 32'hA0);
        chk(32'(oc), 32'h1);
        rc(OFS_FLAGS, 32'h0);
        rc(OFS_COUNT, c0);
        wr(OFS_CONTROL, 32'h30);
        chk(32'(oc), 32'h1);
        wr(OFS_CONTROL, 32'h40);
        wr(OFS_CONTROL, 32'hC0);
        chk(32'(oc), 32'h0);
        $display("test force finished");
        wr(OFS_CONTROL, 32'h18);
        wr(OFS_COMPARE, 32'h40);
        rc(OFS_COMPARE, 32'h40);
        wr(OFS_COUNT, 32'h38);
        run(32'h19, 20);
        rc(OFS_FLAGS, 32'h0);
        wr(OFS_COUNT, 32'hF8);
        run(32'h19, 80);
        rc(OFS_FLAGS, 32'h3);
        wr(OFS_CONTROL, 32'h400);
        chk({30'h0, r}, {30'h0, RESP_OKAY});
        chk(32'(oirq), 32'h1);
        wr(4'h6, 32'hFF);
        chk({30'h0, r}, {30'h0, RESP_SLVERR});
        $display("test pwm buffer finished");
        give_verdict();
    end
endmodule : timer8_counter_compare_tb_top
